// [rtl/udf_cfg_if.sv]
`timescale 1ns/1ns
interface udf_cfg_if;
  logic [4:0] phy1_addr;
  logic [4:0] phy2_addr;
  logic phy_valid;
  modport src (output phy1_addr);
  modport calc (input phy1_addr, output phy2_addr, output phy_valid);
endinterface

// [rtl/udf_phy_addr.sv]
`timescale 1ns/1ns
module udf_phy_addr
  import udf_pkg::*;
(
  udf_cfg_if.calc cfg // Port 1 address in, port 2 address out
);
  always_comb
  begin
    cfg.phy2_addr = cfg.phy1_addr + PHY_ONE;
    cfg.phy_valid = (cfg.phy1_addr != PHY_NA_ZERO) && (cfg.phy1_addr != PHY_NA_1E)
      && (cfg.phy1_addr != PHY_NA_1F);
  end
endmodule

// [rtl/udf_pkg.sv]
package udf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NPORT = 3;
  localparam logic [7:0] FWD_CTRL_OFS = 8'h0e;
  localparam logic [7:0] PHY_CFG_OFS = 8'h0f;
  localparam int FWD_EN_BIT = 7;
  localparam int DRIVE_BIT = 6;
  localparam int PHY_LSB = 3;
  localparam logic FWD_EN_RST = 1'h0;
  localparam logic DRIVE_RST = 1'h1;
  localparam logic [2:0] PORT_MASK_RST = 3'h7;
  localparam logic [4:0] PHY_ADDR_RST = 5'h01;
  localparam logic [4:0] PHY_NA_ZERO = 5'h00;
  localparam logic [4:0] PHY_NA_1E = 5'h1e;
  localparam logic [4:0] PHY_NA_1F = 5'h1f;
  localparam logic [4:0] PHY_ONE = 5'h01;
  localparam logic [7:0] RD_ZERO = 8'h00;
  localparam logic [2:0] RSV_ZERO = 3'h0;
endpackage

// [rtl/udf_regs.sv]
`timescale 1ns/1ns
module udf_regs
  import udf_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [ADDR_W-1:0] reg_addr, // Register offset
  input wire logic [DATA_W-1:0] reg_wdata, // Write data
  input wire logic lookup_done, // Lookup result valid pulse
  input wire logic lookup_miss, // Lookup found no entry
  input wire logic [NPORT-1:0] lookup_ports, // Normal forwarding ports
  output logic [DATA_W-1:0] reg_rdata, // Read data
  output logic [NPORT-1:0] fwd_ports, // Chosen destination ports
  output logic fwd_valid, // Destination valid pulse
  output logic pad_drive_hi, // 1: 16 mA, 0: 8 mA pads
  output logic [4:0] phy1_mgmt_addr, // Port 1 PHY address
  output logic [4:0] phy2_mgmt_addr, // Port 2 PHY address
  output logic phy_addr_ok // Programmed address is usable
);
  typedef struct packed {
    logic fwd_en;
    logic drive;
    logic [NPORT-1:0] mask;
    logic [4:0] phy;
    logic [DATA_W-1:0] rdata;
    logic [NPORT-1:0] ports;
    logic valid;
    logic [4:0] phy2;
    logic ok;
  } udf_state_type;

  udf_state_type s_q;
  udf_state_type s_d;
  udf_cfg_if cfg_bus();

  assign cfg_bus.phy1_addr = s_q.phy;
  udf_phy_addr u_phy_addr (
    .cfg(cfg_bus)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (reg_wr && reg_addr == FWD_CTRL_OFS)
    begin
      s_d.fwd_en = reg_wdata[FWD_EN_BIT];
      s_d.drive = reg_wdata[DRIVE_BIT];
      s_d.mask = reg_wdata[NPORT-1:0];
    end
    if (reg_wr && reg_addr == PHY_CFG_OFS)
      s_d.phy = reg_wdata[DATA_W-1:PHY_LSB];
    if (reg_rd)
    begin
      unique case (reg_addr)
        FWD_CTRL_OFS: s_d.rdata = {s_q.fwd_en, s_q.drive, RSV_ZERO, s_q.mask};
        PHY_CFG_OFS: s_d.rdata = {s_q.phy, RSV_ZERO};
        default: s_d.rdata = RD_ZERO;
      endcase
    end
    if (lookup_done)
    begin
      s_d.valid = 1'b1;
      if (lookup_miss && s_q.fwd_en)
        s_d.ports = s_q.mask;
      else
        s_d.ports = lookup_ports;
    end
    s_d.phy2 = cfg_bus.phy2_addr;
    s_d.ok = cfg_bus.phy_valid;
    if (!rst_b)
    begin
      s_d = '0;
      s_d.drive = DRIVE_RST;
      s_d.fwd_en = FWD_EN_RST;
      s_d.mask = PORT_MASK_RST;
      s_d.phy = PHY_ADDR_RST;
    end
  end

  always_ff @(posedge core_clk)
    s_q <= s_d;

  assign reg_rdata = s_q.rdata;
  assign fwd_ports = s_q.ports;
  assign fwd_valid = s_q.valid;
  assign pad_drive_hi = s_q.drive;
  assign phy1_mgmt_addr = s_q.phy;
  assign phy2_mgmt_addr = s_q.phy2;
  assign phy_addr_ok = s_q.ok;

  // Requests and lookups as sampled at a clock edge
  sequence miss_seen;
    lookup_done && lookup_miss && s_q.fwd_en;
  endsequence

  sequence fwd_write_s;
    reg_wr && reg_addr == FWD_CTRL_OFS;
  endsequence

  sequence fwd_read_s;
    reg_rd && !reg_wr && reg_addr == FWD_CTRL_OFS;
  endsequence

  sequence phy_write_s;
    reg_wr && reg_addr == PHY_CFG_OFS;
  endsequence

  sequence phy_read_s;
    reg_rd && !reg_wr && reg_addr == PHY_CFG_OFS;
  endsequence

  sequence idle_gap_s;
    !reg_wr && !reg_rd;
  endsequence

  // Forwarding decisions
  a_miss_uses_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
    miss_seen ##0 (reg_wr == 1'b0) |=> (fwd_valid && fwd_ports == $past(s_q.mask)))
    else $error("miss not steered by mask");

  a_known_normal: assert property (@(posedge core_clk) disable iff (!rst_b)
    lookup_done && !lookup_miss |=> fwd_ports == $past(lookup_ports))
    else $error("known destination altered");

  a_disabled_normal: assert property (@(posedge core_clk) disable iff (!rst_b)
    lookup_done && !s_q.fwd_en |=> fwd_ports == $past(lookup_ports))
    else $error("mask used while disabled");

  a_valid_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    lookup_done |=> fwd_valid)
    else $error("lookup result not flagged");

  a_valid_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    !lookup_done |=> !fwd_valid)
    else $error("result flagged without lookup");

  a_ports_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !lookup_done |=> $stable(fwd_ports))
    else $error("ports changed without lookup");

  // Register storage and read-back
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_rd && reg_addr == PHY_CFG_OFS |=> reg_rdata[PHY_LSB-1:0] == RSV_ZERO)
    else $error("reserved bits not zero");

  a_fwd_reserved: assert property (@(posedge core_clk) disable iff (!rst_b)
    fwd_read_s |=> reg_rdata[DRIVE_BIT-1:NPORT] == RSV_ZERO)
    else $error("forwarding reserved bits not zero");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_rd && reg_addr != FWD_CTRL_OFS && reg_addr != PHY_CFG_OFS |=> reg_rdata == RD_ZERO)
    else $error("unmapped read not zero");

  a_unmapped_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_wr && reg_addr != FWD_CTRL_OFS && reg_addr != PHY_CFG_OFS |=> $stable(s_q.mask) && $stable(phy1_mgmt_addr))
    else $error("unmapped write altered a register");

  a_rdata_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  a_rdata_fwd: assert property (@(posedge core_clk) disable iff (!rst_b)
    fwd_read_s |=> reg_rdata[NPORT-1:0] == $past(s_q.mask))
    else $error("mask read wrong");

  a_enable_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    fwd_write_s |=> s_q.fwd_en == $past(reg_wdata[FWD_EN_BIT]))
    else $error("enable not written");

  a_mask_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    fwd_write_s |=> s_q.mask == $past(reg_wdata[NPORT-1:0]))
    else $error("mask not written");

  a_mask_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == FWD_CTRL_OFS) |=> $stable(s_q.mask) && $stable(s_q.fwd_en))
    else $error("forwarding config changed without write");

  a_mask_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    fwd_write_s ##1 idle_gap_s ##1 fwd_read_s
    |=> reg_rdata[NPORT-1:0] == $past(reg_wdata[NPORT-1:0], 3))
    else $error("mask readback wrong");

  a_enable_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
    fwd_write_s ##1 idle_gap_s ##1 fwd_read_s
    |=> reg_rdata[FWD_EN_BIT] == $past(reg_wdata[FWD_EN_BIT], 3))
    else $error("enable readback wrong");

  a_reset_vals: assert property (@(posedge core_clk)
    !rst_b |=> s_q.mask == PORT_MASK_RST && s_q.phy == PHY_ADDR_RST && !s_q.fwd_en)
    else $error("reset values wrong");

  // PHY management addresses
  a_phy_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    phy_write_s |=> phy1_mgmt_addr == $past(reg_wdata[DATA_W-1:PHY_LSB]))
    else $error("phy address not written");

  a_phy_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == PHY_CFG_OFS) |=> $stable(phy1_mgmt_addr))
    else $error("phy address changed without write");

  a_rdata_phy: assert property (@(posedge core_clk) disable iff (!rst_b)
    phy_read_s |=> reg_rdata[DATA_W-1:PHY_LSB] == $past(s_q.phy))
    else $error("phy address read wrong");

  a_phy_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
    phy_write_s ##1 idle_gap_s ##1 phy_read_s
    |=> reg_rdata[DATA_W-1:PHY_LSB] == $past(reg_wdata[DATA_W-1:PHY_LSB], 3))
    else $error("phy address readback wrong");

  // Derived outputs lag the stored address by one edge, so skip the edge after reset
  a_port2_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(rst_b) |-> phy2_mgmt_addr == $past(phy1_mgmt_addr) + PHY_ONE)
    else $error("port 2 address wrong");

  a_phy_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(rst_b) |-> phy_addr_ok == ($past(phy1_mgmt_addr) != PHY_NA_ZERO
    && $past(phy1_mgmt_addr) != PHY_NA_1E && $past(phy1_mgmt_addr) != PHY_NA_1F))
    else $error("phy address flag wrong");
endmodule

// [verification/tb_udf_regs.sv]
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb_udf_regs;
  import udf_pkg::*;
  logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, lookup_done = 0, lookup_miss = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, m_fwd = 8'h47, m_phy = 8'h08;
  logic [2:0] lookup_ports = 3'h0, fwd_ports;
  logic fwd_valid, pad_drive_hi, phy_addr_ok, exp_ok;
  logic [4:0] phy1_mgmt_addr, phy2_mgmt_addr;
  logic [15:0] rnd = 16'hdd13;
  int errors = 0, samples_checked = 0;
  always #5 core_clk = ~core_clk;
  udf_regs dut (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .lookup_done(lookup_done), .lookup_miss(lookup_miss), .lookup_ports(lookup_ports),
    .reg_rdata(reg_rdata), .fwd_ports(fwd_ports), .fwd_valid(fwd_valid), .pad_drive_hi(pad_drive_hi),
    .phy1_mgmt_addr(phy1_mgmt_addr), .phy2_mgmt_addr(phy2_mgmt_addr), .phy_addr_ok(phy_addr_ok));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic lk(input logic miss, input logic [2:0] p);
    @(posedge core_clk);
    lookup_done <= 1'b1;
    lookup_miss <= miss;
    lookup_ports <= p;
    @(posedge core_clk);
    lookup_done <= 1'b0;
    #1;
    `CHK("fwd_valid", 1'b1, fwd_valid)
    `CHK("fwd_ports", (miss && m_fwd[7]) ? m_fwd[2:0] : p, fwd_ports)
  endtask
  task automatic test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(FWD_CTRL_OFS, 8'h47);
    rd(PHY_CFG_OFS, 8'h08);
    lk(1'b1, 3'h2);
    repeat (40)
    begin
      rnd = lfsr(rnd);
      acc(1'b1, FWD_CTRL_OFS, rnd[7:0]);
      m_fwd = rnd[7:0] & 8'hc7;
      rd(FWD_CTRL_OFS, m_fwd);
      `CHK("pad_drive_hi", m_fwd[6], pad_drive_hi)
      acc(1'b1, PHY_CFG_OFS, rnd[15:8]);
      m_phy = rnd[15:8] & 8'hf8;
      exp_ok = !(m_phy[7:3] inside {PHY_NA_ZERO, PHY_NA_1E, PHY_NA_1F});
      rd(PHY_CFG_OFS, m_phy);
      `CHK("phy1_mgmt_addr", m_phy[7:3], phy1_mgmt_addr)
      `CHK("phy2_mgmt_addr", m_phy[7:3] + 5'h01, phy2_mgmt_addr)
      `CHK("phy_addr_ok", exp_ok, phy_addr_ok)
      lk(rnd[0], rnd[3:1]);
      lk(~rnd[0], rnd[6:4]);
    end
    acc(1'b1, 8'h33, rnd[7:0]);
    rd(8'h33, 8'h00);
    rd(FWD_CTRL_OFS, m_fwd);
    rd(PHY_CFG_OFS, m_phy);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    m_fwd = 8'h47;
    m_phy = 8'h08;
    #1;
    `CHK("fwd_valid", 1'b0, fwd_valid)
    `CHK("phy1_mgmt_addr", m_phy[7:3], phy1_mgmt_addr)
    rd(FWD_CTRL_OFS, m_fwd);
    rd(PHY_CFG_OFS, m_phy);
    `CHK("phy2_mgmt_addr", m_phy[7:3] + 5'h01, phy2_mgmt_addr)
    `CHK("phy_addr_ok", 1'b1, phy_addr_ok)
    lk(1'b1, 3'h5);
    test_done;
  end
  initial
  begin
    #50000;
    errors++;
    test_done;
  end
endmodule
